/* include/tmwd_pkg.sv */
// Constants shared by the timer and watchdog unit.
// Assumes a single 25 MHz system clock and a 32-bit Avalon-MM register port.
package tmwd_pkg;

	// ------------------------------------------------------------
	// Clock rates in Hz
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 32'h017D_7840;      // 25 MHz block clock
	localparam int unsigned LOW_OSC_HZ = 32'h0005_91C8;  // 365 kHz oscillator
	localparam int unsigned LF_TICK_HZ = LOW_OSC_HZ / 2; // 182.5 kHz
	localparam int unsigned WD_TICK_HZ = 32'h0000_0B22;  // 2.85 kHz
	localparam int unsigned SYS_HZ_20 = 32'h0131_2D00;   // 20 MHz
	localparam int unsigned SYS_HZ_10 = 32'h0098_9680;   // 10 MHz
	localparam int unsigned SYS_HZ_5 = 32'h004C_4B40;    // 5 MHz

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned TICK_MS = 32'h0000_000A;     // 10 ms
	localparam int unsigned MS_PER_S = 32'h0000_03E8;
	localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int SHORT_W = 12;
	localparam int LONG_W = 32;
	localparam int WD_W = 10;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MATCH0 = 8'h10;
	localparam logic [7:0] REG_MATCH1 = 8'h14;
	localparam logic [7:0] REG_MATCH2 = 8'h18;
	localparam logic [7:0] REG_MATCH3 = 8'h1C;
	localparam logic [7:0] REG_COUNT0 = 8'h20;
	localparam logic [7:0] REG_COUNT1 = 8'h24;
	localparam logic [7:0] REG_COUNT2 = 8'h28;
	localparam logic [7:0] REG_COUNT3 = 8'h2C;
	localparam logic [7:0] REG_WD_CTRL = 8'h30;
	localparam logic [7:0] REG_WD_FEED = 8'h34;
	localparam logic [7:0] REG_WD_NMI = 8'h38;
	localparam logic [7:0] REG_WD_LOAD = 8'h3C;
	localparam logic [7:0] REG_WD_COUNT = 8'h40;

	// ------------------------------------------------------------
	// Control fields and reset values
	// ------------------------------------------------------------
	localparam int CTRL_EN_LSB = 0;     // 4 timer enables
	localparam int CTRL_FREE_LSB = 4;   // 4 free-running selects
	localparam int CTRL_CHAIN_BIT = 8;
	localparam int CTRL_GATE_BIT = 9;
	localparam int CTRL_SEL_LSB = 10;   // 2-bit system clock select
	localparam logic [11:0] CTRL_RESET = 12'h200;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [11:0] MATCH_S_RESET = 12'hFFF;
	localparam logic [31:0] MATCH_L_RESET = 32'hFFFF_FFFF;
	localparam logic [9:0] WD_NMI_RESET = 10'h300;
	localparam logic [9:0] WD_LOAD_RESET = 10'h3FF;

	typedef enum logic [1:0] {
		TMWD_SYS_20 = 2'h0,
		TMWD_SYS_10 = 2'h1,
		TMWD_SYS_5 = 2'h2
	} tmwd_sysclk_t;

endpackage : tmwd_pkg

/* hdl/tmwd_rate_gen.sv */
// Fractional divider giving one-cycle enable pulses at a chosen rate.
// Assumes rate_hz stays below the block clock rate; zero stops the pulses.
`timescale 1ns/1ps
module tmwd_rate_gen (
	input wire logic clk,            // Block clock
	input wire logic reset,          // Synchronous reset
	input wire logic [31:0] rate_hz, // Wanted pulse rate
	output logic tick                // One-cycle enable
);
	import tmwd_pkg::*;

	logic [31:0] acc;
	logic [31:0] next_acc;

	// Phase sum for this cycle
	always_comb begin
		next_acc = acc + rate_hz;
	end

	// Wrap the phase and emit a pulse on each overflow
	always_ff @(posedge clk) begin
		if (reset) begin
			acc <= 32'h0;
			tick <= 1'b0;
		end else if (next_acc >= CLK_HZ) begin
			acc <= next_acc - CLK_HZ;
			tick <= 1'b1;
		end else begin
			acc <= next_acc;
			tick <= 1'b0;
		end
	end

endmodule : tmwd_rate_gen

/* hdl/tmwd_timer.sv */
// One match timer of selectable width, advanced by an enable pulse.
// Assumes tick is a one-cycle pulse on the block clock.
`timescale 1ns/1ps
module tmwd_timer #(
	parameter int W = 12
) (
	input wire logic clk,            // Block clock
	input wire logic reset,          // Synchronous reset
	input wire logic enable,         // Run; low clears and re-arms
	input wire logic free_run,       // 1 free-running, 0 single-shot
	input wire logic tick,           // Count pulse
	input wire logic [W-1:0] match,  // Match value
	output logic [W-1:0] count,      // Current count
	output logic timeout             // One-cycle match pulse
);
	logic done;

	// Count toward the single match value, then stop or restart
	always_ff @(posedge clk) begin
		if (reset || !enable) begin
			count <= '0;
			done <= 1'b0;
			timeout <= 1'b0;
		end else if (tick && !done && count == match) begin
			count <= '0;
			timeout <= 1'b1;
			done <= !free_run;
		end else begin
			timeout <= 1'b0;
			if (tick && !done) begin
				count <= count + 1'b1;
			end
		end
	end

	a_single_stop: assert property (@(posedge clk) disable iff (reset)
		timeout && !free_run |=> (!timeout && count == '0) [*3])
		else $error("single-shot timer did not stop");

endmodule : tmwd_timer

/* hdl/tmwd_top.sv */
// Timer and watchdog unit: four match timers, system tick, watchdog.
// Assumes one 25 MHz clock, synchronous reset and an Avalon-MM master.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module tmwd_top #(
	parameter int unsigned TICK_CYCLES = tmwd_pkg::TICK_CYC
) (
	input wire logic clk,                 // 25 MHz clock
	input wire logic reset,               // Synchronous reset
	input wire logic [7:0] address,       // Byte address
	input wire logic read,                // Read request
	input wire logic write,               // Write request
	input wire logic [31:0] writedata,    // Write data
	input wire logic [3:0] byteenable,    // Byte lanes
	output logic [31:0] readdata,         // Read data
	output logic waitrequest,             // Stall
	output logic [3:0] timer_irq,         // Masked timeout flags
	output logic timer_out,               // Shared event line
	output logic system_tick_exception,   // 10 ms pulse
	output logic wd_nmi,                  // Watchdog warning level
	output logic system_reset             // Watchdog reset pulse
);
	import tmwd_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic ack;
	logic req;
	logic wr_go;
	logic [31:0] next_readdata;
	logic [11:0] ctrl;
	logic [3:0] irq_mask;
	logic [3:0] flags;
	logic [3:0] flag_clr;
	logic [SHORT_W-1:0] match_s [2];
	logic [LONG_W-1:0] match_l [2];
	logic [SHORT_W-1:0] count_s [2];
	logic [LONG_W-1:0] count_l [2];
	logic [3:0] to;
	logic tick_lf;
	logic tick_sys;
	logic tick_wd;
	logic [31:0] lf_rate;
	logic [31:0] sys_rate;
	logic wd_en;
	logic wd_feed;
	logic wd_expire;
	logic [WD_W-1:0] wd_nmi_val;
	logic [WD_W-1:0] wd_load;
	logic [WD_W-1:0] wd_count;
	logic [31:0] st_cnt;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Merge write data into a word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// Long-timer clock rate for a select code
	function automatic logic [31:0] sys_hz(input logic [1:0] sel);
		logic [31:0] r;
		r = SYS_HZ_5;
		if (sel == TMWD_SYS_20) begin
			r = SYS_HZ_20;
		end else if (sel == TMWD_SYS_10) begin
			r = SYS_HZ_10;
		end
		return r;
	endfunction : sys_hz

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------

	// Every access waits exactly one cycle
	assign req = read | write;
	assign waitrequest = req & ~ack;
	assign wr_go = write & ack;

	// Acknowledge phase
	always_ff @(posedge clk) begin
		if (reset) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// Read mux, unmapped addresses read as zero
	always_comb begin
		next_readdata = 32'h0;
		if (address == REG_CTRL) begin
			next_readdata[11:0] = ctrl;
		end else if (address == REG_MASK) begin
			next_readdata[3:0] = irq_mask;
		end else if (address == REG_STATUS) begin
			next_readdata[3:0] = flags;
		end else if (address == REG_MATCH0) begin
			next_readdata[SHORT_W-1:0] = match_s[0];
		end else if (address == REG_MATCH1) begin
			next_readdata[SHORT_W-1:0] = match_s[1];
		end else if (address == REG_MATCH2) begin
			next_readdata = match_l[0];
		end else if (address == REG_MATCH3) begin
			next_readdata = match_l[1];
		end else if (address == REG_COUNT0) begin
			next_readdata[SHORT_W-1:0] = count_s[0];
		end else if (address == REG_COUNT1) begin
			next_readdata[SHORT_W-1:0] = count_s[1];
		end else if (address == REG_COUNT2) begin
			next_readdata = count_l[0];
		end else if (address == REG_COUNT3) begin
			next_readdata = count_l[1];
		end else if (address == REG_WD_CTRL) begin
			next_readdata[0] = wd_en;
		end else if (address == REG_WD_NMI) begin
			next_readdata[WD_W-1:0] = wd_nmi_val;
		end else if (address == REG_WD_LOAD) begin
			next_readdata[WD_W-1:0] = wd_load;
		end else if (address == REG_WD_COUNT) begin
			next_readdata[WD_W-1:0] = wd_count;
		end
	end

	// Read data captured in the stall cycle, held until the next read
	always_ff @(posedge clk) begin
		if (reset) begin
			readdata <= 32'h0;
		end else if (read && !ack) begin
			readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------

	// Control, mask and match values
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
			irq_mask <= MASK_RESET;
			match_s[0] <= MATCH_S_RESET;
			match_s[1] <= MATCH_S_RESET;
			match_l[0] <= MATCH_L_RESET;
			match_l[1] <= MATCH_L_RESET;
		end else if (wr_go) begin
			if (address == REG_CTRL) begin
				ctrl <= 12'(be_merge({20'h0, ctrl}, writedata, byteenable));
			end else if (address == REG_MASK) begin
				irq_mask <= 4'(be_merge({28'h0, irq_mask}, writedata, byteenable));
			end else if (address == REG_MATCH0) begin
				match_s[0] <= 12'(be_merge({20'h0, match_s[0]}, writedata, byteenable));
			end else if (address == REG_MATCH1) begin
				match_s[1] <= 12'(be_merge({20'h0, match_s[1]}, writedata, byteenable));
			end else if (address == REG_MATCH2) begin
				match_l[0] <= be_merge(match_l[0], writedata, byteenable);
			end else if (address == REG_MATCH3) begin
				match_l[1] <= be_merge(match_l[1], writedata, byteenable);
			end
		end
	end

	// ------------------------------------------------------------
	// Timer clocks
	// ------------------------------------------------------------

	// Gate and select the two count rates
	always_comb begin
		lf_rate = ctrl[CTRL_GATE_BIT] ? LF_TICK_HZ : 32'h0;
		sys_rate = 32'h0;
		if (ctrl[CTRL_GATE_BIT]) begin
			sys_rate = sys_hz(ctrl[CTRL_SEL_LSB +: 2]);
		end
	end

	// Short-timer rate
	tmwd_rate_gen u_lf_rate (
		.clk(clk),
		.reset(reset),
		.rate_hz(lf_rate),
		.tick(tick_lf)
	);

	// Long-timer rate
	tmwd_rate_gen u_sys_rate (
		.clk(clk),
		.reset(reset),
		.rate_hz(sys_rate),
		.tick(tick_sys)
	);

	// Watchdog rate, never gated
	tmwd_rate_gen u_wd_rate (
		.clk(clk),
		.reset(reset),
		.rate_hz(WD_TICK_HZ),
		.tick(tick_wd)
	);

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------

	// Short timers; timer 1 counts timer 0 wraps when chained
	tmwd_timer #(.W(SHORT_W)) u_short0 (
		.clk(clk),
		.reset(reset),
		.enable(ctrl[CTRL_EN_LSB]),
		.free_run(ctrl[CTRL_FREE_LSB]),
		.tick(tick_lf),
		.match(match_s[0]),
		.count(count_s[0]),
		.timeout(to[0])
	);

	tmwd_timer #(.W(SHORT_W)) u_short1 (
		.clk(clk),
		.reset(reset),
		.enable(ctrl[CTRL_EN_LSB+1]),
		.free_run(ctrl[CTRL_FREE_LSB+1]),
		.tick(ctrl[CTRL_CHAIN_BIT] ? to[0] : tick_lf),
		.match(match_s[1]),
		.count(count_s[1]),
		.timeout(to[1])
	);

	// Long timers on the system clock rate
	for (genvar g = 0; g < 2; g++) begin : g_long
		tmwd_timer #(.W(LONG_W)) u_long (
			.clk(clk),
			.reset(reset),
			.enable(ctrl[CTRL_EN_LSB+2+g]),
			.free_run(ctrl[CTRL_FREE_LSB+2+g]),
			.tick(tick_sys),
			.match(match_l[g]),
			.count(count_l[g]),
			.timeout(to[2+g])
		);
	end

	// ------------------------------------------------------------
	// Timeout flags and outputs
	// ------------------------------------------------------------

	// Write-one-to-clear on the status byte
	always_comb begin
		flag_clr = 4'h0;
		if (wr_go && address == REG_STATUS && byteenable[0]) begin
			flag_clr = writedata[3:0];
		end
	end

	// Sticky flags, a new timeout beats a clear
	always_ff @(posedge clk) begin
		if (reset) begin
			flags <= 4'h0;
		end else begin
			flags <= (flags & ~flag_clr) | to;
		end
	end

	// Masked interrupts and the shared line
	always_ff @(posedge clk) begin
		if (reset) begin
			timer_irq <= 4'h0;
			timer_out <= 1'b0;
		end else begin
			timer_irq <= flags & irq_mask;
			timer_out <= |to;
		end
	end

	// ------------------------------------------------------------
	// System tick
	// ------------------------------------------------------------

	// Free-running 10 ms period
	always_ff @(posedge clk) begin
		if (reset) begin
			st_cnt <= 32'h0;
			system_tick_exception <= 1'b0;
		end else if (st_cnt == 32'(TICK_CYCLES - 1)) begin
			st_cnt <= 32'h0;
			system_tick_exception <= 1'b1;
		end else begin
			st_cnt <= st_cnt + 32'h1;
			system_tick_exception <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------

	assign wd_feed = wr_go && address == REG_WD_FEED;
	assign wd_expire = wd_en && tick_wd && !wd_feed && wd_count == wd_load;

	// Enable, warning value and timeout value
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_en <= 1'b0;
			wd_nmi_val <= WD_NMI_RESET;
			wd_load <= WD_LOAD_RESET;
		end else if (wd_expire) begin
			wd_en <= 1'b0;
		end else if (wr_go) begin
			if (address == REG_WD_CTRL && byteenable[0]) begin
				wd_en <= writedata[0];
			end else if (address == REG_WD_NMI) begin
				wd_nmi_val <= 10'(be_merge({22'h0, wd_nmi_val}, writedata, byteenable));
			end else if (address == REG_WD_LOAD) begin
				wd_load <= 10'(be_merge({22'h0, wd_load}, writedata, byteenable));
			end
		end
	end

	// Counter, held at zero while disabled
	always_ff @(posedge clk) begin
		if (reset || !wd_en) begin
			wd_count <= '0;
		end else if (wd_feed) begin
			wd_count <= '0;
		end else if (tick_wd) begin
			wd_count <= (wd_count == wd_load) ? '0 : wd_count + 1'b1;
		end
	end

	// Warning level and reset pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_nmi <= 1'b0;
			system_reset <= 1'b0;
		end else begin
			wd_nmi <= wd_en && wd_count >= wd_nmi_val;
			system_reset <= wd_expire;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	sequence s_wd_fire;
		wd_expire;
	endsequence

	sequence s_wd_after;
		!wd_en && system_reset ##1 !system_reset;
	endsequence

	a_bus_one_wait: assert property (@(posedge clk) disable iff (reset)
		req && waitrequest |=> !waitrequest)
		else $error("access stalled more than one cycle");

	a_wd_fire_reset: assert property (@(posedge clk) disable iff (reset)
		s_wd_fire |=> s_wd_after)
		else $error("watchdog expiry did not reset and disable");

	a_wd_idle_quiet: assert property (@(posedge clk) disable iff (reset)
		!wd_en |=> !system_reset && wd_count == '0)
		else $error("disabled watchdog acted");

	a_wd_feed_restart: assert property (@(posedge clk) disable iff (reset)
		wd_en && wd_feed |=> wd_count == '0 && !system_reset)
		else $error("feed did not restart the watchdog");

	a_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
		to[0] |=> flags[0])
		else $error("timeout flag lost");

	a_mask_gate_short: assert property (@(posedge clk) disable iff (reset)
		timer_irq[1:0] == $past(irq_mask[1:0] & flags[1:0]))
		else $error("masked short timer interrupt passed");

	a_mask_gate_long: assert property (@(posedge clk) disable iff (reset)
		timer_irq[3:2] == $past(irq_mask[3:2] & flags[3:2]))
		else $error("masked long timer interrupt passed");

	a_shared_line: assert property (@(posedge clk) disable iff (reset)
		|to |=> timer_out)
		else $error("timer event missing on shared line");

	a_tick_phase: assert property (@(posedge clk) disable iff (reset)
		system_tick_exception |-> st_cnt == 32'h0 ##1 !system_tick_exception)
		else $error("system tick out of phase");

endmodule : tmwd_top

/* test/tmwd_testbench.sv */
// Self-checking bench for the timer and watchdog unit.
// Assumes tmwd_pkg is compiled first; the bench is the only bus master.
`timescale 1ns/1ps
module testbench;
	import tmwd_pkg::*;

	// ------------------------------------------------------------
	// Signals and tallies
	// ------------------------------------------------------------
	localparam int unsigned ST = 20;
	localparam int LIMIT = 60000;
	logic clk = 0, reset = 1, read = 0, write = 0, w;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0, rd, readdata;
	logic [3:0] byteenable = 4'hF, timer_irq;
	logic waitrequest, timer_out, system_tick_exception, wd_nmi, system_reset;
	int miscompares = 0, checks = 0, cyc = 0, pulses = 0, sr_cnt = 0;
	int st_last = 0, st_gap = 0, n = 0, t0 = 0;
	bit nmi_seen = 0;
	logic [7:0] ra[9] = '{REG_CTRL, REG_MASK, REG_STATUS, REG_MATCH0, REG_MATCH2,
		REG_WD_CTRL, REG_WD_NMI, REG_WD_LOAD, 8'h80};
	logic [31:0] rv[9] = '{32'h200, 32'h0, 32'h0, 32'hFFF, 32'hFFFF_FFFF,
		32'h0, 32'h300, 32'h3FF, 32'h0};
	int unsigned sysr[3] = '{SYS_HZ_20, SYS_HZ_10, SYS_HZ_5};

	tmwd_top #(.TICK_CYCLES(ST)) i_dut (
		.clk(clk),
		.reset(reset),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.timer_irq(timer_irq),
		.timer_out(timer_out),
		.system_tick_exception(system_tick_exception),
		.wd_nmi(wd_nmi),
		.system_reset(system_reset)
	);

	// 25 MHz clock
	initial forever #20 clk = ~clk;

	// Event tallies and hang guard, sampled mid-cycle where outputs are settled
	always @(negedge clk) begin
		cyc++;
		if (timer_out === 1'b1) pulses++;
		if (system_reset === 1'b1) sr_cnt++;
		if (wd_nmi === 1'b1) nmi_seen = 1;
		if (system_tick_exception === 1'b1) begin
			st_gap = cyc - st_last;
			st_last = cyc;
		end
		if (cyc == LIMIT) begin
			miscompares++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// One Avalon-MM access, held to the rising edge after waitrequest is seen low at a falling edge
	task automatic bus(input bit is_wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !is_wr;
		write <= is_wr;
		do begin
			@(negedge clk);
			w = waitrequest;
			rd = readdata;
			@(posedge clk);
		end while (w !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask : rdchk

	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask : idle

	task automatic close_out();
		$display("Checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		// Reset values, an unmapped hole and the read-only COUNT2 counter
		for (int i = 0; i < 9; i++) rdchk("reset_value", ra[i], rv[i]);
		wr(REG_COUNT2, 32'h1234);
		wr(8'h80, 32'h5A5A);
		rdchk("count2_ro", REG_COUNT2, 32'h0);
		rdchk("hole", 8'h80, 32'h0);
		wr(REG_MATCH1, 32'hFFFF_F123);
		rdchk("match1_width", REG_MATCH1, 32'h123);
		// Long timer free-running at each system clock choice
		wr(REG_MATCH2, 32'h2);
		wr(REG_MASK, 32'h4);
		for (int s = 0; s < 3; s++) begin
			wr(REG_CTRL, 32'h244 | (s << 10));
			idle(20);
			n = pulses;
			idle(150);
			t0 = 150 * (sysr[s] / 10000) / (CLK_HZ / 10000) / 3;
			chk("pulse_rate", 1, {31'h0, (pulses - n - t0) inside {[-2:2]}});
		end
		rdchk("status2", REG_STATUS, 32'h4);
		@(negedge clk);
		chk("irq2", 4, {28'h0, timer_irq});
		// Gating the timer clock freezes the timers
		wr(REG_CTRL, 32'h044);
		idle(5);
		n = pulses;
		idle(100);
		chk("gated", n, pulses);
		// Single-shot long timer fires once
		wr(REG_CTRL, 32'h200);
		wr(REG_STATUS, 32'hF);
		wr(REG_MATCH3, 32'h3);
		wr(REG_MASK, 32'h8);
		n = pulses;
		wr(REG_CTRL, 32'h208);
		idle(60);
		chk("single_shot", n + 1, pulses);
		@(negedge clk);
		chk("irq3", 8, {28'h0, timer_irq});
		rdchk("count3", REG_COUNT3, 32'h0);
		wr(REG_STATUS, 32'h8);
		idle(4);
		rdchk("status_clear", REG_STATUS, 32'h0);
		@(negedge clk);
		chk("irq3_clear", 0, {28'h0, timer_irq});
		// Short timer free-running, masked then passed
		wr(REG_MATCH0, 32'h1);
		wr(REG_MATCH1, 32'h1);
		wr(REG_MASK, 32'h0);
		wr(REG_CTRL, 32'h211);
		idle(400);
		rdchk("t0_status", REG_STATUS, 32'h1);
		@(negedge clk);
		chk("t0_masked", 0, {28'h0, timer_irq});
		wr(REG_MASK, 32'h1);
		idle(3);
		@(negedge clk);
		chk("t0_passed", 1, {28'h0, timer_irq});
		// Chained short timers: timer 1 steps on timer 0 timeouts
		wr(REG_CTRL, 32'h200);
		wr(REG_STATUS, 32'hF);
		wr(REG_CTRL, 32'h333);
		idle(350);
		rdchk("chain_early", REG_STATUS, 32'h1);
		idle(400);
		rdchk("chain_late", REG_STATUS, 32'h3);
		chk("tick_gap", ST, st_gap);
		// Watchdog: idle until enabled, fed, then left to expire
		chk("wd_idle", 0, sr_cnt);
		wr(REG_WD_NMI, 32'h1);
		wr(REG_WD_LOAD, 32'h1);
		wr(REG_WD_CTRL, 32'h1);
		repeat (4) begin
			idle(6000);
			wr(REG_WD_FEED, 32'h0);
		end
		t0 = cyc;
		chk("wd_fed", 0, sr_cnt);
		for (int i = 0; i < 20000 && sr_cnt == 0; i++) @(posedge clk);
		chk("wd_period", 1, {31'h0, (cyc - t0) inside {[8700:17700]}});
		chk("wd_nmi", 1, {31'h0, nmi_seen});
		rdchk("wd_auto_off", REG_WD_CTRL, 32'h0);
		rdchk("wd_count_off", REG_WD_COUNT, 32'h0);
		chk("wd_reset_once", 1, sr_cnt);
		close_out();
	end
endmodule : testbench
